/* rtl/ams_adc_mode_sequencer.v */
// Conversion sequencer of a successive-approximation converter with an APB register port.
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
`include "ams_adc_regs.vh"

module ams_adc_mode_sequencer (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire [79:0] analogInputs,
    input wire [49:0] altGroupInputs,
    output wire convRequest,
    output wire convBusy
);

    // ======================================================================
    // Decoding and timing helpers

    // Register index codes; results take 8..15, so bit 3 alone marks them
    localparam IDX_CTRL0 = 4'h0;
    localparam IDX_CTRL1 = 4'h1;
    localparam IDX_STATUS = 4'h2;
    localparam IDX_NONE = 4'h3;

    // Register index: 0 ctrl0, 1 ctrl1, 2 status, 8..15 results, 3 unmapped.
    // Misaligned and out-of-range addresses all fall to the unmapped code.
    function [3:0] decodeAddr;
        input [7:0] addr;
        begin
            if (addr == `AMS_OFF_CTRL0) begin
                decodeAddr = IDX_CTRL0;
            end else if (addr == `AMS_OFF_CTRL1) begin
                decodeAddr = IDX_CTRL1;
            end else if (addr == `AMS_OFF_STATUS) begin
                decodeAddr = IDX_STATUS;
            end else if (addr >= `AMS_OFF_RESULT0 && addr <= `AMS_OFF_RESULT7
                         && addr[1:0] == 2'h0) begin
                decodeAddr = {1'b1, addr[4:2] - 3'h4};
            end else begin
                decodeAddr = IDX_NONE;
            end
        end
    endfunction

    // Conversion length by resolution and hold option
    function [5:0] convLength;
        input res10;
        input hold;
        begin
            if (hold) begin
                convLength = res10 ? `AMS_CYC_HOLD_10 : `AMS_CYC_HOLD_8;
            end else begin
                convLength = res10 ? `AMS_CYC_NOHOLD_10 : `AMS_CYC_NOHOLD_8;
            end
        end
    endfunction

    // ======================================================================
    // State and register storage

    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;

    reg state_ff;
    reg nxt_state;
    reg [1:0] mode_ff;
    reg [2:0] chanSel_ff;
    reg [1:0] clkDiv_ff;
    reg startFlag_ff;
    reg res10_ff;
    reg hold_ff;
    reg altGroup_ff;
    reg [1:0] sweepSize_ff;
    reg convReq_ff;
    reg [1:0] divCnt_ff;
    reg [5:0] cycCnt_ff;
    reg [5:0] nxt_cycCnt;
    reg [2:0] curChan_ff;
    reg [2:0] nxt_curChan;
    reg [9:0] heldSample_ff;
    reg [9:0] resultMem [0:7];
    reg finishConv;
    reg [31:0] readMux;
    integer idx;

    wire [3:0] wrIndex;
    wire [3:0] rdIndex;
    wire apbWrite;
    wire apbSetup;
    wire convTick;
    wire [5:0] lastCycle;
    wire doneTick;
    wire sampleTick;
    wire sweepMode;
    wire [2:0] lastChan;
    wire [9:0] liveValue;
    wire [9:0] convValue;
    wire [9:0] laneValue [0:7];
    wire wrCtrl0;
    wire wrCtrl1;
    wire wrStatus;

    // ======================================================================
    // APB slave: zero wait states, read data captured in the setup cycle
    assign wrIndex = decodeAddr(paddr);
    assign rdIndex = wrIndex;
    assign apbWrite = psel & penable & pwrite;
    assign apbSetup = psel & ~penable;
    assign pready = 1'b1;
    assign pslverr = psel & penable & (wrIndex == IDX_NONE);
    assign convRequest = convReq_ff;
    assign convBusy = state_ff;

    // Write strobes per register; one decode shared by all writers
    assign wrCtrl0 = apbWrite && (wrIndex == IDX_CTRL0);
    assign wrCtrl1 = apbWrite && (wrIndex == IDX_CTRL1);
    assign wrStatus = apbWrite && (wrIndex == IDX_STATUS);

    // Read multiplexer; reserved bits read as zero
    always @* begin
        readMux = 32'h0000_0000;
        case (rdIndex)
            IDX_CTRL0: begin
                readMux[`AMS_C0_MODE_HI:`AMS_C0_MODE_LO] = mode_ff;
                readMux[`AMS_C0_CHAN_HI:`AMS_C0_CHAN_LO] = chanSel_ff;
                readMux[`AMS_C0_DIV_HI:`AMS_C0_DIV_LO] = clkDiv_ff;
                readMux[`AMS_C0_START] = startFlag_ff;
            end
            IDX_CTRL1: begin
                readMux[`AMS_C1_RES10] = res10_ff;
                readMux[`AMS_C1_HOLD] = hold_ff;
                readMux[`AMS_C1_ALT] = altGroup_ff;
                readMux[`AMS_C1_SWEEP_HI:`AMS_C1_SWEEP_LO] = sweepSize_ff;
            end
            IDX_STATUS: begin
                readMux[`AMS_ST_REQ] = convReq_ff;
                readMux[`AMS_ST_BUSY] = state_ff;
                readMux[`AMS_ST_CHAN_HI:`AMS_ST_CHAN_LO] = curChan_ff;
            end
            IDX_NONE: begin
                readMux = 32'h0000_0000;
            end
            default: begin
                readMux[`AMS_RES_W-1:0] = resultMem[rdIndex[2:0]];
            end
        endcase
    end

    // Read data is a flop so it is steady through the access phase
    always @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (apbSetup) begin
            prdata <= readMux;
        end
    end

    // ======================================================================
    // Control registers; a software write wins over a hardware clear of
    // the start flag so a restart issued at the finishing edge is kept
    always @(posedge clk) begin
        if (sys_rst) begin
            mode_ff <= `AMS_MODE_ONESHOT;
            chanSel_ff <= 3'h0;
            clkDiv_ff <= `AMS_DIV_BY4;
            startFlag_ff <= 1'b0;
            res10_ff <= 1'b0;
            hold_ff <= 1'b0;
            altGroup_ff <= 1'b0;
            sweepSize_ff <= 2'h0;
        end else begin
            if (finishConv) begin
                startFlag_ff <= 1'b0;
            end
            if (wrCtrl0) begin
                mode_ff <= pwdata[`AMS_C0_MODE_HI:`AMS_C0_MODE_LO];
                chanSel_ff <= pwdata[`AMS_C0_CHAN_HI:`AMS_C0_CHAN_LO];
                clkDiv_ff <= pwdata[`AMS_C0_DIV_HI:`AMS_C0_DIV_LO];
                startFlag_ff <= pwdata[`AMS_C0_START];
            end
            if (wrCtrl1) begin
                res10_ff <= pwdata[`AMS_C1_RES10];
                hold_ff <= pwdata[`AMS_C1_HOLD];
                altGroup_ff <= pwdata[`AMS_C1_ALT];
                sweepSize_ff <= pwdata[`AMS_C1_SWEEP_HI:`AMS_C1_SWEEP_LO];
            end
        end
    end

    // Request bit: set by hardware, cleared by software writing zero.
    // Setting wins when both land on the same edge.
    always @(posedge clk) begin
        if (sys_rst) begin
            convReq_ff <= 1'b0;
        end else if (finishConv) begin
            convReq_ff <= 1'b1;
        end else if (wrStatus && !pwdata[`AMS_ST_REQ]) begin
            convReq_ff <= 1'b0;
        end
    end

    // ======================================================================
    // Conversion clock enable; an invalid divisor code runs as divide by 4.
    // The divider runs free, so the first tick of a conversion lands up to
    // divisor-1 clocks after busy rises; software sees only this jitter.
    always @(posedge clk) begin
        if (sys_rst) begin
            divCnt_ff <= 2'h0;
        end else begin
            divCnt_ff <= divCnt_ff + 2'h1;
        end
    end

    assign convTick = (clkDiv_ff == `AMS_DIV_BY1) ||
                      (clkDiv_ff == `AMS_DIV_BY2 && divCnt_ff[0]) ||
                      (divCnt_ff == 2'h3 && clkDiv_ff != `AMS_DIV_BY2);

    // ======================================================================
    // Input routing: alternate group stands in for lanes zero to four
    genvar gi;
    generate
        for (gi = 0; gi < `AMS_NUM_CH; gi = gi + 1) begin : g_lane
            if (gi < `AMS_NUM_ALT) begin : g_alt
                assign laneValue[gi] = altGroup_ff ?
                    altGroupInputs[gi*`AMS_RES_W +: `AMS_RES_W] :
                    analogInputs[gi*`AMS_RES_W +: `AMS_RES_W];
            end else begin : g_pri
                assign laneValue[gi] = analogInputs[gi*`AMS_RES_W +: `AMS_RES_W];
            end
        end
    endgenerate

    assign liveValue = laneValue[curChan_ff];
    assign sweepMode = mode_ff[1];
    assign lastChan = {sweepSize_ff, 1'b1};
    assign lastCycle = convLength(res10_ff, hold_ff) - 6'h01;
    assign doneTick = (state_ff == ST_CONV) && convTick && (cycCnt_ff == lastCycle);
    assign sampleTick = (state_ff == ST_CONV) && convTick && hold_ff &&
                        (cycCnt_ff == `AMS_CYC_SAMPLE - 6'h01);
    // Held value with hold enabled, otherwise the input at the last cycle
    assign convValue = (hold_ff ? heldSample_ff : liveValue) &
                       (res10_ff ? `AMS_MASK_10BIT : `AMS_MASK_8BIT);

    // Sampling window: the input is followed for three conversion clock cycles, then held
    always @(posedge clk) begin
        if (sys_rst) begin
            heldSample_ff <= 10'h000;
        end else if (sampleTick) begin
            heldSample_ff <= liveValue;
        end
    end

    // ======================================================================
    // Sequencer next state. A stop from software wins over completion in
    // the same cycle, so an aborted conversion never stores its result.
    always @* begin
        nxt_state = state_ff;
        nxt_cycCnt = cycCnt_ff;
        nxt_curChan = curChan_ff;
        finishConv = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (startFlag_ff) begin
                    nxt_state = ST_CONV;
                    nxt_cycCnt = 6'h00;
                    nxt_curChan = sweepMode ? 3'h0 : chanSel_ff;
                end
            end
            ST_CONV: begin
                if (!startFlag_ff) begin
                    // Software stop aborts the conversion in flight
                    nxt_state = ST_IDLE;
                end else if (doneTick) begin
                    nxt_cycCnt = 6'h00;
                    case (mode_ff)
                        `AMS_MODE_ONESHOT: begin
                            finishConv = 1'b1;
                            nxt_state = ST_IDLE;
                        end
                        `AMS_MODE_REPEAT: begin
                            nxt_curChan = curChan_ff;
                        end
                        `AMS_MODE_SWEEP: begin
                            if (curChan_ff == lastChan) begin
                                finishConv = 1'b1;
                                nxt_state = ST_IDLE;
                            end else begin
                                nxt_curChan = curChan_ff + 3'h1;
                            end
                        end
                        `AMS_MODE_RSWEEP0: begin
                            // Wrap straight back to lane zero, no idle cycle
                            nxt_curChan = (curChan_ff == lastChan) ?
                                          3'h0 : curChan_ff + 3'h1;
                        end
                        default: begin
                            nxt_state = ST_IDLE;
                        end
                    endcase
                end else if (convTick) begin
                    nxt_cycCnt = cycCnt_ff + 6'h01;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
            cycCnt_ff <= 6'h00;
            curChan_ff <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            cycCnt_ff <= nxt_cycCnt;
            curChan_ff <= nxt_curChan;
        end
    end

    // ======================================================================
    // Result store: each finished conversion lands in its lane's register;
    // older results of other lanes are left untouched
    always @(posedge clk) begin
        if (sys_rst) begin
            for (idx = 0; idx < `AMS_NUM_CH; idx = idx + 1) begin
                resultMem[idx] <= 10'h000;
            end
        end else if (doneTick && startFlag_ff) begin
            resultMem[curChan_ff] <= convValue;
        end
    end

endmodule // ams_adc_mode_sequencer

/* rtl/ams_adc_regs.vh */
// Register map, field positions and timing constants of the converter mode sequencer.
`ifndef AMS_ADC_REGS_VH
`define AMS_ADC_REGS_VH

// ==========================================================================
// Register byte offsets
`define AMS_OFF_CTRL0 8'h00
`define AMS_OFF_CTRL1 8'h04
`define AMS_OFF_STATUS 8'h08
`define AMS_OFF_RESULT0 8'h10
`define AMS_OFF_RESULT7 8'h2C

// ==========================================================================
// Control 0 fields
`define AMS_C0_MODE_LO 0
`define AMS_C0_MODE_HI 1
`define AMS_C0_CHAN_LO 2
`define AMS_C0_CHAN_HI 4
`define AMS_C0_DIV_LO 5
`define AMS_C0_DIV_HI 6
`define AMS_C0_START 7

// Control 1 fields
`define AMS_C1_RES10 0
`define AMS_C1_HOLD 1
`define AMS_C1_ALT 2
`define AMS_C1_SWEEP_LO 3
`define AMS_C1_SWEEP_HI 4

// Status fields
`define AMS_ST_REQ 0
`define AMS_ST_BUSY 1
`define AMS_ST_CHAN_LO 2
`define AMS_ST_CHAN_HI 4

// ==========================================================================
// Mode and divisor encodings
`define AMS_MODE_ONESHOT 2'h0
`define AMS_MODE_REPEAT 2'h1
`define AMS_MODE_SWEEP 2'h2
`define AMS_MODE_RSWEEP0 2'h3
`define AMS_DIV_BY4 2'h0
`define AMS_DIV_BY2 2'h1
`define AMS_DIV_BY1 2'h2

// ==========================================================================
// Timing in conversion clock cycles
`define AMS_CYC_HOLD_10 6'h21
`define AMS_CYC_HOLD_8 6'h1C
`define AMS_CYC_NOHOLD_10 6'h3B
`define AMS_CYC_NOHOLD_8 6'h31
`define AMS_CYC_SAMPLE 6'h03

// Widths and reset values
`define AMS_RES_W 10
`define AMS_NUM_CH 8
`define AMS_NUM_ALT 5
`define AMS_MASK_8BIT 10'h3FC
`define AMS_MASK_10BIT 10'h3FF
`define AMS_RST_CTRL0 8'h00
`define AMS_RST_CTRL1 5'h00

`endif

/* tb/ams_adc_mode_sequencer_chk.sv */
// Concurrent checker of the converter sequencer ports.
`timescale 1ns/1ps
module ams_adc_mode_sequencer_chk (
    input logic clk,
    input logic sys_rst,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic pready,
    input logic pslverr,
    input logic convRequest,
    input logic convBusy
);
    // ====
    // Shadow of software config
    logic [1:0] mode_ff;
    logic [1:0] div_ff;
    logic hold_ff;
    logic res10_ff;
    logic [12:0] busyCnt_ff;
    wire wrAcc = psel && penable && pwrite;
    wire startWr = wrAcc && paddr == 8'h00 && pwdata[7] && !convBusy;
    wire stopWr = wrAcc && paddr == 8'h00 && !pwdata[7];
    wire [3:0] dv = (div_ff == 2'h1) ? 4'h2 : (div_ff == 2'h2) ? 4'h1 : 4'h4;
    wire [5:0] nCyc = hold_ff ? (res10_ff ? 6'h21 : 6'h1C) : (res10_ff ? 6'h3B : 6'h31);
    wire [12:0] tMax = dv * nCyc;
    // Config only moves while idle, so a plain write shadow is enough
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_ff <= 2'h0;
            div_ff <= 2'h0;
            hold_ff <= 1'b0;
            res10_ff <= 1'b0;
            busyCnt_ff <= 13'h0000;
        end else begin
            if (wrAcc && paddr == 8'h00) begin
                mode_ff <= pwdata[1:0];
                div_ff <= pwdata[6:5];
            end
            if (wrAcc && paddr == 8'h04) begin
                hold_ff <= pwdata[1];
                res10_ff <= pwdata[0];
            end
            busyCnt_ff <= convBusy ? busyCnt_ff + 13'h0001 : 13'h0000;
        end
    end
    // ====
    // Properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence seqConvEnd;
        convBusy ##1 !convBusy && $rose(convRequest);
    endsequence
    AST_PREADY: assert property (pready)
        else $error("pready low");
    AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    AST_MISALIGNED: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    // Start flag lands at the write edge, busy flops one edge after that
    AST_START_BUSY: assert property (startWr |-> ##2 convBusy)
        else $error("start write did not raise busy");
    AST_BUSY_CAUSE: assert property ($rose(convBusy) |-> $past(startWr, 2))
        else $error("busy rose without start write");
    AST_REQ_AT_END: assert property ($rose(convRequest) |-> $fell(convBusy))
        else $error("request raised while converting");
    AST_ONESHOT_TIME: assert property (mode_ff == 2'h0 ##0 seqConvEnd |->
        busyCnt_ff >= tMax - dv + 13'h0001 && busyCnt_ff <= tMax)
        else $error("one-shot conversion length wrong");
    AST_NO_REQ_REPEAT: assert property (mode_ff[0] |-> !$rose(convRequest))
        else $error("request raised in a repeat mode");
    AST_RUN_UNTIL_STOP: assert property (mode_ff[0] && $fell(convBusy) |->
        $past(stopWr) || $past(stopWr, 2))
        else $error("repeat mode stopped by itself");
    AST_REQ_HOLDS: assert property (convRequest && !(wrAcc && paddr == 8'h08 && !pwdata[0])
        |=> convRequest)
        else $error("request dropped without clear");
endmodule // ams_adc_mode_sequencer_chk

bind ams_adc_mode_sequencer ams_adc_mode_sequencer_chk i_chk (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .convRequest(convRequest), .convBusy(convBusy)
);

/* tb/ams_analog_src.sv */
// Analog source model: one settled quantized level per input lane.
`timescale 1ns/1ps
module ams_analog_src (
    input wire logic clk,
    input wire logic ldEn,
    input wire logic [3:0] ldIdx,
    input wire logic [9:0] ldVal,
    output logic [79:0] analogInputs,
    output logic [49:0] altGroupInputs
);
    // Levels hold between loads, like a settled source; the bench loads
    // every lane before the first conversion, so no start value is needed
    // Lanes 0..7 primary, 8..12 alternate group
    always @(posedge clk) begin
        if (ldEn && ldIdx < 4'h8) analogInputs[ldIdx * 10 +: 10] <= ldVal;
        if (ldEn && ldIdx >= 4'h8) altGroupInputs[(ldIdx - 4'h8) * 10 +: 10] <= ldVal;
    end
endmodule // ams_analog_src

/* tb/ams_adc_mode_sequencer_tb.sv */
// Self-checking testbench of the converter mode sequencer.
`timescale 1ns/1ps
module ams_adc_mode_sequencer_tb;
    logic clk, sys_rst, psel, penable, pwrite, ldEn, res10, alt, errSeen;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd, seed;
    logic [3:0] ldIdx;
    logic [9:0] ldVal;
    logic [9:0] primVal [8];
    logic [9:0] altVal [5];
    logic [2:0] ch;
    logic [1:0] dv;
    wire pready, pslverr, convRequest, convBusy;
    wire [31:0] prdata;
    wire [79:0] analogInputs;
    wire [49:0] altGroupInputs;
    int n_fail, n_tests, i, k;

    ams_adc_mode_sequencer i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .analogInputs(analogInputs),
        .altGroupInputs(altGroupInputs), .convRequest(convRequest), .convBusy(convBusy));
    ams_analog_src i_src (.clk(clk), .ldEn(ldEn), .ldIdx(ldIdx), .ldVal(ldVal),
        .analogInputs(analogInputs), .altGroupInputs(altGroupInputs));

    // ====
    // Clock, helpers and bus tasks
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic [31:0] xs(input [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Alternate lanes only exist for inputs 0..4; 8-bit drops the two low bits
    function automatic [9:0] expRes(input [2:0] c);
        return ((alt && c < 3'h5) ? altVal[c] : primVal[c]) & (res10 ? 10'h3FF : 10'h3FC);
    endfunction
    task automatic chk(input [31:0] seen, input [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Waits an edge first so a release never meets the next setup in one step
    task automatic apb(input logic w, input [7:0] a, input [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdChk(input [7:0] a, input [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    // Loads every lane with a fresh random level
    task automatic randIn();
        for (int j = 0; j < 13; j++) begin
            seed = xs(seed);
            if (j < 8) primVal[j] = seed[9:0];
            else altVal[j - 8] = seed[9:0];
            @(posedge clk);
            ldEn <= 1'b1;
            ldIdx <= 4'(j);
            ldVal <= seed[9:0];
        end
        @(posedge clk);
        ldEn <= 1'b0;
    endtask
    task automatic waitIdle();
        int t;
        t = 0;
        repeat (2) @(negedge clk);
        while (convBusy && t < 9000) begin
            @(negedge clk);
            t++;
        end
        chk({31'h0, convBusy}, 32'h0000_0000);
    endtask
    task automatic test_done();
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #1_500_000;
        n_fail++;
        test_done();
    end

    // ====
    // Scenarios
    initial begin
        {sys_rst, psel, penable, pwrite, ldEn, res10, alt} = 7'h40;
        {paddr, pwdata, ldIdx, ldVal} = 54'h0;
        {n_fail, n_tests, seed} = {32'h0, 32'h0, 32'h0000_0016};
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        for (k = 0; k < 4; k++) rdChk(8'(k * 4), 32'h0000_0000);
        apb(1'b0, 8'h30, 32'h0000_0000);
        chk({rd[30:0], errSeen}, 32'h0000_0001);
        apb(1'b0, 8'h11, 32'h0000_0000);
        chk({rd[30:0], errSeen}, 32'h0000_0001);
        // One-shot over each divisor with random config
        for (i = 0; i < 6; i++) begin
            randIn();
            seed = xs(seed);
            {res10, alt, ch, dv} = {seed[0], seed[2], seed[6:4], 2'(i % 3)};
            apb(1'b1, 8'h04, {27'h0, 2'h3, alt, seed[1], res10});
            apb(1'b1, 8'h00, {24'h0, 1'b1, dv, ch, 2'h0});
            waitIdle();
            rdChk({ch, 2'h0} + 8'h10, expRes(ch));
            apb(1'b0, 8'h08, 32'h0000_0000);
            chk(rd[1:0], 32'h0000_0001);
            chk({31'h0, convRequest}, 32'h0000_0001);
            apb(1'b0, 8'h00, 32'h0000_0000);
            chk(rd[7], 32'h0000_0000);
            apb(1'b1, 8'h08, 32'h0000_0000);
        end
        // Repeat on input five: results refresh, hardware never stops it
        {res10, alt} = 2'h2;
        apb(1'b1, 8'h04, 32'h0000_0001);
        apb(1'b1, 8'h00, 32'h0000_00D5);
        for (k = 0; k < 2; k++) begin
            randIn();
            repeat (130) @(posedge clk);
            rdChk(8'h24, expRes(3'h5));
        end
        rdChk(8'h08, 32'h0000_0016);
        rdChk(8'h00, 32'h0000_00D5);
        apb(1'b1, 8'h00, 32'h0000_0055);
        waitIdle();
        // Single sweep over every size
        for (i = 0; i < 4; i++) begin
            randIn();
            seed = xs(seed);
            {res10, alt} = seed[1:0];
            apb(1'b1, 8'h04, {27'h0, 2'(i), alt, seed[2], res10});
            apb(1'b1, 8'h00, {24'h0, 1'b1, seed[4:3], 5'h2});
            waitIdle();
            for (k = 0; k < 2 * i + 2; k++) rdChk(8'(k * 4) + 8'h10, expRes(3'(k)));
            apb(1'b0, 8'h08, 32'h0000_0000);
            chk(rd[1:0], 32'h0000_0001);
            chk({31'h0, convRequest}, 32'h0000_0001);
            apb(1'b0, 8'h00, 32'h0000_0000);
            chk(rd[7], 32'h0000_0000);
            apb(1'b1, 8'h08, 32'h0000_0000);
        end
        // Repeat sweep 0 on four alternate inputs, two refresh rounds
        {res10, alt} = 2'h3;
        apb(1'b1, 8'h04, 32'h0000_000F);
        apb(1'b1, 8'h00, 32'h0000_00C3);
        for (i = 0; i < 2; i++) begin
            randIn();
            repeat (300) @(posedge clk);
            for (k = 0; k < 4; k++) rdChk(8'(k * 4) + 8'h10, expRes(3'(k)));
        end
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk(rd[1:0], 32'h0000_0002);
        apb(1'b1, 8'h00, 32'h0000_0043);
        waitIdle();
        test_done();
    end
endmodule // ams_adc_mode_sequencer_tb
